/* File: core/ssim_pkg.sv */
// Constants, types and carriers shared by the serial port interrupt block.
package ssim_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // Width of the byte address seen by the register slave.
  localparam int unsigned ADDR_W = 4;
  // Byte offsets of the four registers.
  localparam logic [3:0] OFS_ENABLE = 4'h0;
  localparam logic [3:0] OFS_RAW = 4'h4;
  localparam logic [3:0] OFS_MASKED = 4'h8;
  localparam logic [3:0] OFS_CLEAR = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  // Number of interrupt sources and their bit positions.
  localparam int unsigned NSRC = 4;
  localparam int unsigned BIT_TX = 3;
  localparam int unsigned BIT_RX = 2;
  localparam int unsigned BIT_RT = 1;
  localparam int unsigned BIT_ROR = 0;
  // Number of sticky event flags (time-out and overrun, bits 1 and 0).
  localparam int unsigned NSTICKY = 2;
  // Value of the enable field after reset.
  localparam logic [3:0] ENABLE_RST = 4'h0;
  // FIFO fill thresholds, in entries.
  localparam int unsigned CNT_W = 4;
  localparam logic [3:0] TX_LEVEL_MAX = 4'h4;
  localparam logic [3:0] RX_LEVEL_MIN = 4'h4;
  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Upper read bits that are always zero.
  localparam logic [27:0] PAD_ZERO = 28'h0000000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Which register an address selects.
  typedef enum {
    SSIM_REG_ENABLE,
    SSIM_REG_RAW,
    SSIM_REG_MASKED,
    SSIM_REG_CLEAR,
    SSIM_REG_NONE
  } ssim_reg_t;

  // Status arriving from the FIFO and sequencing logic of the port.
  typedef struct packed {
    logic port_enable;
    logic [CNT_W-1:0] tx_count;
    logic [CNT_W-1:0] rx_count;
    logic timeout_evt;
    logic overrun_evt;
  } ssim_src_t;

  // Whole state of the register slave.
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NSRC-1:0] enable;
    logic irq;
  } ssim_state_t;

  // Whole state of one sticky flag.
  typedef struct packed {
    logic flag;
  } ssim_flag_state_t;

endpackage

/* File: core/ssim_sticky_flag.sv */
// One sticky event flag: set by a pulse, cleared by software.
`timescale 1ns/1ns
module ssim_sticky_flag
  import ssim_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Event and clear pulses.
  input wire logic set_pulse,
  input wire logic clear_pulse,
  // Flag value.
  output logic flag
);

  // Current and next state.
  ssim_flag_state_t st_r;
  ssim_flag_state_t st_nxt;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    st_nxt = st_r;
    if (set_pulse) begin
      st_nxt.flag = 1'b1;
    end else if (clear_pulse) begin
      st_nxt.flag = 1'b0;
    end
  end

  // State register, cleared by reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The flag comes straight from the flip-flop.
  assign flag = st_r.flag;

  // The flag rises after an event even if a clear came with it.
  a_set_wins: assert property (
    @(posedge clk) disable iff (!nrst) set_pulse |=> flag)
    else $error("sticky flag lost an event");

  // A flag holds until a clear without an event arrives.
  a_flag_holds: assert property (
    @(posedge clk) disable iff (!nrst)
    (flag && !clear_pulse) |=> flag)
    else $error("sticky flag dropped without a clear");

endmodule

/* File: core/ssim_core.sv */
// Interrupt enable, raw and masked status of the serial port, AXI4-Lite.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module ssim_core
  import ssim_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address channel.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Status of the port's FIFOs and event detectors.
  input wire ssim_src_t src,
  // Combined interrupt to the processor.
  output logic serial_port_irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  // Current and next state of the slave.
  ssim_state_t st_r;
  ssim_state_t st_nxt;
  // Raw and masked interrupt flags.
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] masked;
  // Sticky flags with their set and clear pulses.
  logic [NSTICKY-1:0] sticky;
  logic [NSTICKY-1:0] set_pulse;
  logic [NSTICKY-1:0] clear_pulse;
  // Channel handshakes completing this cycle.
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  // A write whose address and data are both present this cycle.
  logic wr_commit;
  // Address, data and strobes of the write being committed.
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  // Decoded targets of the write and the read.
  ssim_reg_t wr_reg;
  ssim_reg_t rd_reg;
  // Source conditions of the two level interrupts.
  logic tx_level_raw;
  logic rx_level_raw;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Maps a byte address to a register; low address bits must be zero.
  function automatic ssim_reg_t ssim_decode(input logic [ADDR_W-1:0] a);
    ssim_reg_t r;
    case (a)
      OFS_ENABLE: r = SSIM_REG_ENABLE;
      OFS_RAW: r = SSIM_REG_RAW;
      OFS_MASKED: r = SSIM_REG_MASKED;
      OFS_CLEAR: r = SSIM_REG_CLEAR;
      default: r = SSIM_REG_NONE;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  // Address and data are each held once taken; no new write is taken
  // while a response is still waiting, so at most one write is in flight.
  assign s_axi_awready = !st_r.aw_held && !st_r.bvalid;
  assign s_axi_wready = !st_r.w_held && !st_r.bvalid;
  // One read at a time: the next address waits for the data to go.
  assign s_axi_arready = !st_r.rvalid;

  // Completed transfers on each request channel.
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // The write takes effect on the edge where the later half arrives.
  assign wr_commit = (st_r.aw_held || aw_fire) && (st_r.w_held || w_fire);
  assign wr_addr = st_r.aw_held ? st_r.aw_addr : s_axi_awaddr;
  assign wr_data = st_r.w_held ? st_r.w_data : s_axi_wdata;
  assign wr_strb = st_r.w_held ? st_r.w_strb : s_axi_wstrb;

  // Decoded targets.
  assign wr_reg = ssim_decode(wr_addr);
  assign rd_reg = ssim_decode(s_axi_araddr);

  // ----------------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------------
  // Transmit level: room for more data, or the port switched off.
  assign tx_level_raw = (src.tx_count <= TX_LEVEL_MAX) ||
                        !src.port_enable;
  // Receive level: at least half the receive FIFO is filled.
  assign rx_level_raw = src.rx_count >= RX_LEVEL_MIN;

  // Event pulses that set the sticky flags, by bit position.
  assign set_pulse[BIT_RT] = src.timeout_evt;
  assign set_pulse[BIT_ROR] = src.overrun_evt;

  // One sticky flag per event source; a one in the matching bit of a
  // write to the clear register drops it, a zero leaves it alone.
  genvar gi;
  generate
    for (gi = 0; gi < NSTICKY; gi = gi + 1) begin : g_sticky
      assign clear_pulse[gi] = wr_commit && (wr_reg == SSIM_REG_CLEAR) &&
                               wr_strb[0] && wr_data[gi];
      ssim_sticky_flag u_flag (
        .clk(clk),
        .nrst(nrst),
        .set_pulse(set_pulse[gi]),
        .clear_pulse(clear_pulse[gi]),
        .flag(sticky[gi])
      );
    end
  endgenerate

  // Raw flags ignore the enables entirely.
  assign raw[BIT_TX] = tx_level_raw;
  assign raw[BIT_RX] = rx_level_raw;
  assign raw[BIT_RT] = sticky[BIT_RT];
  assign raw[BIT_ROR] = sticky[BIT_ROR];

  // Masked flags pass only where the enable bit is one.
  assign masked = raw & st_r.enable;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Captures requests, applies writes, builds read data and the interrupt.
  always_comb begin
    st_nxt = st_r;
    // Hold a write address that arrives before its data.
    if (aw_fire) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    // Hold write data that arrives before its address.
    if (w_fire) begin
      st_nxt.w_held = 1'b1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_strb = s_axi_wstrb;
    end
    // Retire the response once the master has taken it.
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // Apply a complete write and raise its response.
    if (wr_commit) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (wr_reg)
        SSIM_REG_ENABLE: begin
          // Only the four enable bits are kept; upper bits are dropped.
          if (wr_strb[0]) begin
            st_nxt.enable = wr_data[NSRC-1:0];
          end
        end
        SSIM_REG_NONE: begin
          // Nothing lives here: report a slave error.
          st_nxt.bresp = RESP_SLVERR;
        end
        default: begin
          // Status registers ignore writes; the clear acts by pulses.
          st_nxt.bresp = RESP_OKAY;
        end
      endcase
    end
    // Retire read data once the master has taken it.
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    // Capture read data at the edge the address is taken.
    if (ar_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (rd_reg)
        SSIM_REG_ENABLE: begin
          st_nxt.rdata = {PAD_ZERO, st_r.enable};
        end
        SSIM_REG_RAW: begin
          st_nxt.rdata = {PAD_ZERO, raw};
        end
        SSIM_REG_MASKED: begin
          st_nxt.rdata = {PAD_ZERO, masked};
        end
        SSIM_REG_CLEAR: begin
          // Write-only register reads as zero.
          st_nxt.rdata = 32'h00000000;
        end
        default: begin
          st_nxt.rdata = 32'h00000000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Any masked flag drives the combined interrupt.
    st_nxt.irq = |masked;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset leaves all sources disabled and no transfer pending.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.enable <= ENABLE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Response channels and the interrupt come from flip-flops.
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign serial_port_irq = st_r.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // A committed write to the enable register with its low lane on.
  sequence s_enable_write;
    wr_commit && (wr_reg == SSIM_REG_ENABLE) && wr_strb[0];
  endsequence

  // A read address accepted for a given register.
  sequence s_read_of(ssim_reg_t r);
    ar_fire && (rd_reg == r);
  endsequence

  // The enable field takes the low four bits written.
  property p_enable_load;
    logic [NSRC-1:0] v;
    (s_enable_write, v = wr_data[NSRC-1:0]) |=> (st_r.enable == v);
  endproperty

  a_enable_load: assert property (p_enable_load)
    else $error("enable register did not take the written value");

  // Enable bits never change without a write to them.
  a_enable_stable: assert property (
    !(wr_commit && (wr_reg == SSIM_REG_ENABLE)) |=> $stable(st_r.enable))
    else $error("enable register changed without a write");

  // While reset is low the enables read as zero one edge later.
  a_enable_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    !nrst |=> (st_r.enable == ENABLE_RST))
    else $error("enable bits not zero after reset");

  // A raw read returns all four source conditions of the take edge.
  a_raw_read: assert property (
    s_read_of(SSIM_REG_RAW) |=>
      (s_axi_rdata == {PAD_ZERO, $past(tx_level_raw), $past(rx_level_raw),
                       $past(sticky)}) && s_axi_rvalid)
    else $error("raw status read returned wrong flags");

  // A masked read returns raw ANDed with the enables.
  a_masked_read: assert property (
    s_read_of(SSIM_REG_MASKED) |=>
      (s_axi_rdata == {PAD_ZERO, $past(raw) & $past(st_r.enable)}))
    else $error("masked status read returned wrong flags");

  // The interrupt follows the OR of the masked flags by one edge.
  a_irq_follow: assert property (
    serial_port_irq == $past(|masked))
    else $error("combined interrupt does not match masked flags");

  // All sources disabled over two edges keep the interrupt low.
  a_irq_gated: assert property (
    (st_r.enable == ENABLE_RST) [*2] |-> !serial_port_irq)
    else $error("interrupt raised with all sources disabled");

  // A clear without a new event drops the flag at the next edge.
  a_clear_drops: assert property (
    (clear_pulse[BIT_RT] && !set_pulse[BIT_RT]) |=> !raw[BIT_RT])
    else $error("time-out flag survived its clear");

  // Writing zero to the clear register leaves the overrun flag set.
  a_zero_clear: assert property (
    (raw[BIT_ROR] && !clear_pulse[BIT_ROR]) |=> raw[BIT_ROR])
    else $error("overrun flag dropped without a clear");

  // Every committed write is answered on the next edge.
  a_write_answer: assert property (
    wr_commit |=> s_axi_bvalid)
    else $error("write response missing");

  // A write to an unmapped address is answered with a slave error.
  a_unmapped_write: assert property (
    (wr_commit && (wr_reg == SSIM_REG_NONE)) |=>
      (s_axi_bvalid && (s_axi_bresp == RESP_SLVERR)))
    else $error("unmapped write not refused");

  // Every accepted read address is answered on the next edge.
  a_read_answer: assert property (
    ar_fire |=> s_axi_rvalid)
    else $error("read data missing");

  // An enable read returns the enable field of the take edge.
  a_enable_read: assert property (
    s_read_of(SSIM_REG_ENABLE) |=>
      (s_axi_rdata == {PAD_ZERO, $past(st_r.enable)}))
    else $error("enable read returned wrong bits");

  // A time-out event shows in the raw word at the next edge.
  a_timeout_sets: assert property (
    src.timeout_evt |=> raw[BIT_RT])
    else $error("time-out event did not set its flag");

  // An overrun event shows in the raw word at the next edge.
  a_overrun_sets: assert property (
    src.overrun_evt |=> raw[BIT_ROR])
    else $error("overrun event did not set its flag");

endmodule

/* File: testbench/ssp_interrupt_mask_status_tb_top.sv */
// Self-checking bench for the serial port interrupt enable and status block.
`timescale 1ns/1ns
module ssp_interrupt_mask_status_tb_top;
  import ssim_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk;
  logic nrst;
  logic [ADDR_W-1:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [ADDR_W-1:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  ssim_src_t src;
  logic serial_port_irq;
  // Counters of failed and total comparisons.
  int mismatches;
  int num_checks;
  // Last read word and last response code.
  logic [31:0] rd;
  logic [1:0] rsp;
  // Source settings and the raw word they should give.
  logic pe_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
  logic [3:0] tx_tab [4] = '{4'h5, 4'h4, 4'h8, 4'h0};
  logic [3:0] rx_tab [4] = '{4'h3, 4'h4, 4'h0, 4'h8};
  logic [31:0] raw_tab [4] = '{32'h0, 32'hC, 32'h8, 32'hC};
  logic [31:0] one_hot;

  ssim_core dut (
    .clk(clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src(src),
    .serial_port_irq(serial_port_irq)
  );

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Compares a seen value with the expected one and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One write; each channel is held until its own handshake edge.
  task automatic axi_write(input logic [3:0] addr, input logic [31:0] data,
      input logic [3:0] strb, output logic [1:0] resp);
    logic aw_hit;
    logic w_hit;
    logic b_hit;
    b_hit = 1'b0;
    s_axi_awaddr <= addr;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_hit) begin
      #1;
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge clk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  // One read; the data is taken at the edge where rvalid is seen.
  task automatic axi_read(input logic [3:0] addr, output logic [31:0] data,
      output logic [1:0] resp);
    logic ar_hit;
    logic r_hit;
    r_hit = 1'b0;
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_hit) begin
      #1;
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid && s_axi_rready;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Full-word write that must be accepted.
  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    axi_write(addr, data, 4'hF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // Read that must be accepted and return the expected word.
  task automatic expect_reg(input logic [3:0] addr, input logic [31:0] exp);
    axi_read(addr, rd, rsp);
    check(rd, exp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask

  // One-cycle pulses on the time-out and overrun event inputs.
  task automatic evt(input logic [1:0] m);
    src.timeout_evt <= m[1];
    src.overrun_evt <= m[0];
    @(posedge clk);
    src.timeout_evt <= 1'b0;
    src.overrun_evt <= 1'b0;
    @(posedge clk);
  endtask

  // The interrupt line lags its cause by one edge, so two are allowed.
  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, serial_port_irq}, {31'h0, exp});
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------------
  // The clock toggles every half period of 20 ns, a 40 ns period.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cuts a hang short; the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // Main sequence of register accesses and source changes.
  initial begin
    nrst = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    // Port off and receive FIFO full, so the raw word is 0xC at reset.
    src = {1'b0, 4'h8, 4'h8, 2'h0};
    mismatches = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Nothing is enabled straight after reset.
    expect_reg(OFS_ENABLE, 32'h0);
    expect_reg(OFS_RAW, 32'hC);
    expect_reg(OFS_MASKED, 32'h0);
    irq_chk(1'b0);
    expect_reg(OFS_CLEAR, 32'h0);
    // Level thresholds at their boundaries and the disabled port.
    for (int i = 0; i < 4; i++) begin
      src.port_enable <= pe_tab[i];
      src.tx_count <= tx_tab[i];
      src.rx_count <= rx_tab[i];
      @(posedge clk);
      expect_reg(OFS_RAW, raw_tab[i]);
    end
    // Each sticky flag holds until a one is written to its own clear bit.
    for (int i = 0; i < 2; i++) begin
      one_hot = 32'h1 << i;
      evt(one_hot[1:0]);
      expect_reg(OFS_RAW, 32'hC | one_hot);
      wr(OFS_CLEAR, 32'h0);
      expect_reg(OFS_RAW, 32'hC | one_hot);
      wr(OFS_CLEAR, 32'h3 ^ one_hot);
      expect_reg(OFS_RAW, 32'hC | one_hot);
      wr(OFS_CLEAR, one_hot);
      expect_reg(OFS_RAW, 32'hC);
    end
    // All four sources present; enable them one at a time.
    evt(2'h3);
    expect_reg(OFS_RAW, 32'hF);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ENABLE, 32'h1 << i);
      expect_reg(OFS_ENABLE, 32'h1 << i);
      expect_reg(OFS_MASKED, 32'h1 << i);
      irq_chk(1'b1);
    end
    // A write without its low byte strobe leaves the enables alone.
    wr(OFS_ENABLE, 32'hF);
    axi_write(OFS_ENABLE, 32'h0, 4'hE, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    expect_reg(OFS_ENABLE, 32'hF);
    // Writes to the status words are ignored.
    wr(OFS_RAW, 32'h0);
    wr(OFS_MASKED, 32'h0);
    expect_reg(OFS_MASKED, 32'hF);
    // Removing every source drops all masked flags and the line.
    src.tx_count <= 4'h8;
    src.rx_count <= 4'h0;
    wr(OFS_CLEAR, 32'h3);
    expect_reg(OFS_RAW, 32'h0);
    expect_reg(OFS_MASKED, 32'h0);
    irq_chk(1'b0);
    // A present source with its enable cleared stays off the line.
    src.tx_count <= 4'h0;
    wr(OFS_ENABLE, 32'h7);
    expect_reg(OFS_RAW, 32'h8);
    expect_reg(OFS_MASKED, 32'h0);
    irq_chk(1'b0);
    // An address outside the map is refused with a slave error.
    axi_read(4'h2, rd, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    // A write outside the map is refused and changes nothing.
    axi_write(4'h6, 32'h0, 4'hF, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    expect_reg(OFS_ENABLE, 32'h7);
    complete_run();
  end
endmodule
